// file: include/ubg_pkg.sv
// package for the serial transceiver baud generator and data buffers
package ubg_pkg;
    localparam logic [11:0] ADDR_RX_DATA = 12'h000;
    localparam logic [11:0] ADDR_TX_DATA = 12'h004;
    localparam logic [11:0] ADDR_DIV_LO = 12'h008;
    localparam logic [11:0] ADDR_DIV_HI = 12'h00C;
    localparam logic [11:0] ADDR_RX_CTRL = 12'h010;
    localparam logic [11:0] ADDR_TX_CTRL = 12'h014;
    localparam logic [11:0] ADDR_BAUD_CTRL = 12'h018;
    localparam logic [11:0] ADDR_PIR = 12'h01C;
    localparam logic [11:0] ADDR_PIE = 12'h020;
    localparam logic [11:0] ADDR_INTCTL = 12'h024;
    localparam logic [11:0] ADDR_PIR_CLR = 12'h028;
    localparam int RX_FLAG_BIT = 5;
    localparam int TX_FLAG_BIT = 4;
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PERIPH_EN_BIT = 6;
    localparam int SYNC_BIT = 4;
    localparam int HSPD_BIT = 2;
    localparam int TRMT_BIT = 1;
    localparam int TX_NINTH_BIT = 0;
    localparam int RX_NINTH_BIT = 0;
    localparam int WIDE_BIT = 3;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] TXCTL_RST = 8'h02;
    localparam logic [5:0] PRE_64 = 6'h3F;
    localparam logic [5:0] PRE_16 = 6'h0F;
    localparam logic [5:0] PRE_4 = 6'h03;
    typedef struct packed {
        logic [7:0] data;
        logic ninth;
    } ubg_char_t;
endpackage

// file: rtl/ubg_core.sv
// baud generator, double-buffered data registers and interrupt flags
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module ubg_core
    import ubg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // shifter side: receive completion and transmit load
    input wire ubg_char_t rx_char,
    input wire logic rx_done,
    input wire logic tx_taken,
    input wire logic tx_shift_empty,
    output ubg_char_t tx_char,
    output logic tx_valid,
    output logic baud_tick,
    output logic irq
);
    logic [7:0] rx_data_r, tx_data_r, div_lo_r, div_hi_r;
    logic [7:0] rx_ctl_r, tx_ctl_r, baud_ctl_r, pie_r, intctl_r;
    logic rx_ninth_r, rx_full_r, tx_full_r;
    logic [15:0] baud_cnt_r, div_n;
    logic [5:0] pre_cnt_r, pre_max;
    logic pre_tick, wr, rd, div_wr;
    logic [7:0] pir;
    logic [31:0] rdata_nxt;
    logic [7:0] lo_load, hi_load;
    logic [15:0] div_load;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign div_wr = wr && (paddr == ADDR_DIV_LO || paddr == ADDR_DIV_HI);

    // control registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            div_lo_r <= RST_BYTE;
            div_hi_r <= RST_BYTE;
            rx_ctl_r <= RST_BYTE;
            tx_ctl_r <= TXCTL_RST;
            baud_ctl_r <= RST_BYTE;
            pie_r <= RST_BYTE;
            intctl_r <= RST_BYTE;
        end
        else if (wr)
        begin
            case (paddr)
                ADDR_DIV_LO: div_lo_r <= pwdata[7:0];
                ADDR_DIV_HI: div_hi_r <= pwdata[7:0];
                ADDR_RX_CTRL: rx_ctl_r <= {pwdata[7:1], 1'b0};
                ADDR_TX_CTRL: tx_ctl_r <= {pwdata[7:2], 1'b0, pwdata[0]};
                ADDR_BAUD_CTRL: baud_ctl_r <= {2'b00, 1'b0, pwdata[4:3], 1'b0,
                    pwdata[1:0]};
                ADDR_PIE: pie_r <= {2'b00, pwdata[5:4], 4'h0};
                ADDR_INTCTL: intctl_r <= {pwdata[7:6], 6'h00};
                default: ;
            endcase
        end
    end

    // prescaler and divisor selection
    always_comb
    begin
        if (tx_ctl_r[SYNC_BIT])
            pre_max = PRE_4;
        else if (!baud_ctl_r[WIDE_BIT] && !tx_ctl_r[HSPD_BIT])
            pre_max = PRE_64;
        else if (baud_ctl_r[WIDE_BIT] && tx_ctl_r[HSPD_BIT])
            pre_max = PRE_4;
        else
            pre_max = PRE_16;
        if (baud_ctl_r[WIDE_BIT])
            div_n = {div_hi_r, div_lo_r};
        else
            div_n = {8'h00, div_lo_r};
    end

    // a restart must start from the byte being written, not the old one
    always_comb
    begin
        lo_load = div_lo_r;
        hi_load = div_hi_r;
        if (wr && paddr == ADDR_DIV_LO)
            lo_load = pwdata[7:0];
        if (wr && paddr == ADDR_DIV_HI)
            hi_load = pwdata[7:0];
        if (baud_ctl_r[WIDE_BIT])
            div_load = {hi_load, lo_load};
        else
            div_load = {8'h00, lo_load};
    end

    assign pre_tick = (pre_cnt_r == 6'h00);

    // restart on divisor write keeps the first bit full length
    always_ff @(posedge ref_clk)
    begin
        if (rst || div_wr)
            pre_cnt_r <= pre_max;
        else if (pre_tick)
            pre_cnt_r <= pre_max;
        else
            pre_cnt_r <= pre_cnt_r - 6'h01;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || div_wr)
        begin
            baud_cnt_r <= div_load;
            baud_tick <= 1'b0;
        end
        else if (pre_tick)
        begin
            baud_tick <= (baud_cnt_r == 16'h0000);
            if (baud_cnt_r == 16'h0000)
                baud_cnt_r <= div_n;
            else
                baud_cnt_r <= baud_cnt_r - 16'h0001;
        end
        else
            baud_tick <= 1'b0;
    end

    // receive holding buffer; reading it frees the slot
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rx_data_r <= RST_BYTE;
            rx_ninth_r <= 1'b0;
            rx_full_r <= 1'b0;
        end
        else if (rx_done)
        begin
            rx_data_r <= rx_char.data;
            rx_ninth_r <= rx_char.ninth;
            rx_full_r <= 1'b1;
        end
        else if (rd && paddr == ADDR_RX_DATA)
            rx_full_r <= 1'b0;
    end

    // transmit holding buffer; shifter takes it when it starts a character
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            tx_data_r <= RST_BYTE;
            tx_full_r <= 1'b0;
        end
        else if (wr && paddr == ADDR_TX_DATA)
        begin
            tx_data_r <= pwdata[7:0];
            tx_full_r <= 1'b1;
        end
        else if (tx_taken)
            tx_full_r <= 1'b0;
    end

    assign tx_char.data = tx_data_r;
    assign tx_char.ninth = tx_ctl_r[TX_NINTH_BIT];
    assign tx_valid = tx_full_r;

    always_comb
    begin
        pir = 8'h00;
        pir[RX_FLAG_BIT] = rx_full_r;
        pir[TX_FLAG_BIT] = !tx_full_r;
    end

    assign irq = intctl_r[GLOBAL_EN_BIT] && intctl_r[PERIPH_EN_BIT]
        && |(pir & pie_r);

    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        case (paddr)
            ADDR_RX_DATA: rdata_nxt[7:0] = rx_data_r;
            ADDR_TX_DATA: rdata_nxt[7:0] = tx_data_r;
            ADDR_DIV_LO: rdata_nxt[7:0] = div_lo_r;
            ADDR_DIV_HI: rdata_nxt[7:0] = div_hi_r;
            ADDR_RX_CTRL:
            begin
                rdata_nxt[7:0] = rx_ctl_r;
                rdata_nxt[RX_NINTH_BIT] = rx_ninth_r;
            end
            ADDR_TX_CTRL: rdata_nxt[7:0] = {tx_ctl_r[7:2], tx_shift_empty,
                tx_ctl_r[0]};
            ADDR_BAUD_CTRL: rdata_nxt[7:0] = baud_ctl_r;
            ADDR_PIR: rdata_nxt[7:0] = pir;
            ADDR_PIE: rdata_nxt[7:0] = pie_r;
            ADDR_INTCTL: rdata_nxt[7:0] = intctl_r;
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    assign prdata = rdata_nxt;
    assign pslverr = 1'b0;

    chk_div_restart: assert property (@(posedge ref_clk) disable iff (rst)
        div_wr |=> baud_cnt_r == div_n && !baud_tick)
        else $error("divisor write did not restart counter");
    chk_hi_ignored: assert property (@(posedge ref_clk) disable iff (rst)
        !baud_ctl_r[WIDE_BIT] |-> div_n[15:8] == 8'h00)
        else $error("high byte used in 8-bit mode");
    chk_sync_rate: assert property (@(posedge ref_clk) disable iff (rst)
        tx_ctl_r[SYNC_BIT] |-> pre_max == PRE_4)
        else $error("sync prescale wrong");
    chk_slow_rate: assert property (@(posedge ref_clk) disable iff (rst)
        !tx_ctl_r[SYNC_BIT] && !baud_ctl_r[WIDE_BIT] && !tx_ctl_r[HSPD_BIT]
        |-> pre_max == PRE_64)
        else $error("slow prescale wrong");
    chk_rx_hold: assert property (@(posedge ref_clk) disable iff (rst)
        rx_done |=> rx_full_r && rx_data_r == $past(rx_char.data))
        else $error("received char not held");
    chk_tx_flag: assert property (@(posedge ref_clk) disable iff (rst)
        tx_taken && !wr |=> pir[TX_FLAG_BIT])
        else $error("tx empty flag not set after load");
    chk_irq_gate: assert property (@(posedge ref_clk) disable iff (rst)
        irq |-> intctl_r[GLOBAL_EN_BIT] && intctl_r[PERIPH_EN_BIT])
        else $error("irq without global enables");

    // a tick right after a reload of zero at the fastest prescale
    sequence fast_reload_seq;
        baud_tick && baud_cnt_r == 16'h0000 && pre_cnt_r == PRE_4 && !div_wr;
    endsequence
    sequence no_restart_seq;
        !div_wr [*3];
    endsequence
    chk_tick_spacing: assert property (@(posedge ref_clk) disable iff (rst)
        fast_reload_seq ##1 no_restart_seq |=> baud_tick)
        else $error("tick spacing wrong");

    // a byte write to either divisor half, seen at its access edge
    sequence lo_write_seq;
        wr && paddr == ADDR_DIV_LO;
    endsequence
    sequence hi_write_seq;
        wr && paddr == ADDR_DIV_HI;
    endsequence
    chk_lo_restart: assert property (@(posedge ref_clk) disable iff (rst)
        lo_write_seq |=> pre_cnt_r == $past(pre_max) && div_lo_r == baud_cnt_r[7:0])
        else $error("low byte write did not restart");
    chk_hi_restart: assert property (@(posedge ref_clk) disable iff (rst)
        hi_write_seq |=> pre_cnt_r == $past(pre_max) && !baud_tick)
        else $error("high byte write did not restart");
    chk_hi_load: assert property (@(posedge ref_clk) disable iff (rst)
        hi_write_seq && !baud_ctl_r[WIDE_BIT] |=> baud_cnt_r[15:8] == 8'h00)
        else $error("high byte loaded in 8-bit mode");
    chk_wide_div: assert property (@(posedge ref_clk) disable iff (rst)
        baud_ctl_r[WIDE_BIT] |-> div_n == {div_hi_r, div_lo_r})
        else $error("wide divisor not concatenated");
    chk_wide_rate: assert property (@(posedge ref_clk) disable iff (rst)
        !tx_ctl_r[SYNC_BIT] && baud_ctl_r[WIDE_BIT] && !tx_ctl_r[HSPD_BIT]
        |-> pre_max == PRE_16)
        else $error("wide low speed prescale wrong");
    chk_fast_rate: assert property (@(posedge ref_clk) disable iff (rst)
        !tx_ctl_r[SYNC_BIT] && tx_ctl_r[HSPD_BIT]
        |-> pre_max == (baud_ctl_r[WIDE_BIT] ? PRE_4 : PRE_16))
        else $error("high speed prescale wrong");
    chk_pre_count: assert property (@(posedge ref_clk) disable iff (rst)
        !pre_tick && !div_wr |=> pre_cnt_r == $past(pre_cnt_r) - 6'h01)
        else $error("prescaler skipped a count");
    chk_cnt_reload: assert property (@(posedge ref_clk) disable iff (rst)
        pre_tick && baud_cnt_r == 16'h0000 && !div_wr
        |=> baud_tick && baud_cnt_r == $past(div_n))
        else $error("counter did not reload");
    chk_tick_pulse: assert property (@(posedge ref_clk) disable iff (rst)
        baud_tick |=> !baud_tick)
        else $error("tick longer than one cycle");
    chk_rx_ninth: assert property (@(posedge ref_clk) disable iff (rst)
        rx_done |=> rx_ninth_r == $past(rx_char.ninth))
        else $error("received ninth bit not held");
    chk_rx_keep: assert property (@(posedge ref_clk) disable iff (rst)
        !rx_done |=> $stable(rx_data_r) && $stable(rx_ninth_r))
        else $error("receive buffer changed without a character");
    chk_rx_clear: assert property (@(posedge ref_clk) disable iff (rst)
        rd && paddr == ADDR_RX_DATA && !rx_done |=> !pir[RX_FLAG_BIT])
        else $error("receive flag not cleared by read");
    chk_tx_load: assert property (@(posedge ref_clk) disable iff (rst)
        wr && paddr == ADDR_TX_DATA
        |=> tx_valid && tx_char.data == $past(pwdata[7:0]))
        else $error("transmit write not buffered");
    chk_tx_hold: assert property (@(posedge ref_clk) disable iff (rst)
        tx_valid && !tx_taken |=> tx_valid)
        else $error("transmit buffer lost before load");
    chk_irq_enable: assert property (@(posedge ref_clk) disable iff (rst)
        irq |-> |(pir & pie_r))
        else $error("irq without an enabled flag");
    chk_upper_zero: assert property (@(posedge ref_clk) disable iff (rst)
        psel |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
endmodule // ubg_core

// file: test/ubg_shifter_model.sv
// far-side shifter model: takes tx characters, delivers rx characters
`timescale 1ns/100ps
module ubg_shifter_model
    import ubg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tx_valid,
    input wire ubg_char_t tx_char,
    input wire logic stall,
    input wire logic send,
    input wire ubg_char_t send_char,
    output ubg_char_t rx_char,
    output logic rx_done,
    output logic tx_taken,
    output logic tx_shift_empty,
    output ubg_char_t last_tx
);
    int busy;
    logic take;
    assign take = tx_valid && !tx_taken && busy == 0 && !stall;
    assign tx_shift_empty = (busy == 0);
    // idle rx bus toggles so stale data never looks valid
    always @(posedge ref_clk)
    begin
        rx_done <= send;
        rx_char <= (send || rst) ? send_char : ~rx_char;
    end
    always @(posedge ref_clk)
    begin
        tx_taken <= !rst && take;
        if (rst)
            busy <= 0;
        else if (take)
        begin
            busy <= 20;
            last_tx <= tx_char;
        end
        else if (busy > 0)
            busy <= busy - 1;
    end
endmodule // ubg_shifter_model

// file: test/ubg_core_test.sv
// self-checking bench for the baud generator and data buffers
`timescale 1ns/100ps
module ubg_core_test;
    import ubg_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, stall = 1'b1, send = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, rx_done, tx_taken, tx_shift_empty, tx_valid;
    logic baud_tick, irq;
    ubg_char_t rx_char, tx_char, last_tx, r, send_char = '0;
    integer seed = 32'hD995;
    int n_errors = 0, tests_run = 0, c, lo, hi;
    always #4 ref_clk = ~ref_clk;
    ubg_core uut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_char(rx_char), .rx_done(rx_done), .tx_taken(tx_taken),
        .tx_shift_empty(tx_shift_empty), .tx_char(tx_char),
        .tx_valid(tx_valid), .baud_tick(baud_tick), .irq(irq));
    ubg_shifter_model far (.ref_clk(ref_clk), .rst(rst),
        .tx_valid(tx_valid), .tx_char(tx_char), .stall(stall), .send(send),
        .send_char(send_char), .rx_char(rx_char), .rx_done(rx_done),
        .tx_taken(tx_taken), .tx_shift_empty(tx_shift_empty),
        .last_tx(last_tx));
    task check(input string nm, input logic [31:0] got, e);
        tests_run++;
        if (got !== e)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, got);
        end
    endtask
    // idle edge first, so back-to-back calls never drive psel twice
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(nm, q, e);
    endtask
    task wait_tick(output int g);
        g = 0;
        do
        begin
            @(posedge ref_clk);
            g++;
        end
        while (baud_tick !== 1'b1);
    endtask
    task irq_sweep(input logic rxf);
        for (int i = 0; i < 16; i++)
        begin
            apb(1'b1, ADDR_PIE, {i[1:0], 4'h0});
            apb(1'b1, ADDR_INTCTL, {i[3:2], 6'h0});
            @(posedge ref_clk);
            check("irq", irq, i[3] & i[2] & (i[1] & rxf | i[0]));
        end
    endtask
    function int pre_of(int m);
        return m[2] ? 4 : m[1] ? (m[0] ? 4 : 16) : (m[0] ? 16 : 64);
    endfunction
    task complete_run;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        #(8 * 60000);
        n_errors++;
        complete_run;
    end
    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rd("rx data", ADDR_RX_DATA, 32'h0);
        rd("tx data", ADDR_TX_DATA, 32'h0);
        rd("div lo", ADDR_DIV_LO, 32'h0);
        rd("div hi", ADDR_DIV_HI, 32'h0);
        rd("tx ctl", ADDR_TX_CTRL, 32'h2);
        rd("baud ctl", ADDR_BAUD_CTRL, 32'h0);
        $display("test reset done");
        for (int m = 0; m < 8; m++)
        begin
            lo = (m == 4) ? 0 : $random(seed) & 3;
            hi = m[1] ? 1 : $random(seed) & 255;
            apb(1'b1, ADDR_TX_CTRL, {m[2], 1'b0, m[0], 2'b0});
            apb(1'b1, ADDR_BAUD_CTRL, {m[1], 3'b0});
            apb(1'b1, ADDR_DIV_HI, hi);
            apb(1'b1, ADDR_DIV_LO, lo);
            wait_tick(c);
            wait_tick(c);
            check("gap", c, (lo + 256 * m[1] + 1) * pre_of(m));
        end
        $display("test rates done");
        apb(1'b1, ADDR_TX_CTRL, 32'h0);
        apb(1'b1, ADDR_BAUD_CTRL, 32'h0);
        apb(1'b1, ADDR_DIV_LO, 32'h3);
        for (int k = 0; k < 2; k++)
        begin
            wait_tick(c);
            repeat (100) @(posedge ref_clk);
            apb(1'b1, k ? ADDR_DIV_HI : ADDR_DIV_LO, k ? 32'h5A : 32'h1);
            wait_tick(c);
            check("restart", c, 32'd129);
        end
        $display("test restart done");
        r = {8'($random(seed)), 1'b1};
        send_char <= r;
        send <= 1'b1;
        @(posedge ref_clk);
        send <= 1'b0;
        rd("rx ctl", ADDR_RX_CTRL, 32'h1);
        rd("flags", ADDR_PIR, 32'h30);
        irq_sweep(1'b1);
        apb(1'b1, ADDR_RX_DATA, 32'hFF);
        rd("rx data", ADDR_RX_DATA, r.data);
        rd("flags", ADDR_PIR, 32'h10);
        rd("hole", 12'h03C, 32'h0);
        irq_sweep(1'b0);
        $display("test receive done");
        r = {8'($random(seed)), 1'b1};
        apb(1'b1, ADDR_TX_CTRL, 32'h1);
        apb(1'b1, ADDR_TX_DATA, r.data);
        rd("flags", ADDR_PIR, 32'h0);
        stall <= 1'b0;
        while (tx_taken !== 1'b1)
            @(posedge ref_clk);
        check("tx char", last_tx, r);
        rd("flags", ADDR_PIR, 32'h10);
        rd("tx ctl", ADDR_TX_CTRL, 32'h1);
        apb(1'b1, ADDR_TX_DATA, 32'h5A);
        @(posedge ref_clk);
        check("tx held", tx_valid, 32'h1);
        $display("test transmit done");
        complete_run;
    end
endmodule // ubg_core_test
